// *** hw/socket_irq_pkg.sv ***
// Functional notes
// - Control bit 7 enables ring indicate use
// - Control bit 6 zero holds card reset
// - Control bit 5 selects memory or I/O
// - Control bit 4 routes status change to PCI
// - Field 3:0 routes card interrupt; zero means PCI; code routes no card interrupt on zero, only status change goes to PCI
// - Code 0010 means SYSTEM_MGMT_INTERRUPT, others IRQ number
// - Status register read-only, upper nibble zero
// - Disabled source flag always reads zero
// - Enabled active source sets flag, raises interrupt
// - Flags clear on read or write-one
// - Bit 3 set on either detect change
// - Bit 2 READY rise, memory card only
// - Bit 1 battery low, memory card only
// - Bit 0 dead, event or ring indicate
// - Registers at 803h and 804h, reset 00h
// - Per-source enables gate each status source
// - Battery pins: 10 low, 0x dead, 11 good
//
// Package of register offsets, field positions and codes for the
// socket control and status-change block. Assumes 12-bit socket offsets.
package socket_irq_pkg;

  // Register map in socket register space
  localparam logic [11:0] CTRL_OFFSET        = 12'h803;
  localparam logic [11:0] FLAGS_OFFSET       = 12'h804;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  localparam logic [7:0]  FLAGS_RESET        = 8'h00;

  // Control register fields
  localparam int          RING_ENABLE_BIT    = 7;
  localparam int          CARD_RUN_BIT       = 6;
  localparam int          CARD_KIND_BIT      = 5;
  localparam int          PCI_ROUTE_BIT      = 4;
  localparam int          ROUTE_FIELD_LSB    = 0;
  localparam int          ROUTE_FIELD_WIDTH  = 4;

  // Status-change flag positions
  localparam int          DETECT_FLAG_BIT    = 3;
  localparam int          READY_FLAG_BIT     = 2;
  localparam int          LOW_FLAG_BIT       = 1;
  localparam int          DEAD_FLAG_BIT      = 0;
  localparam int          FLAG_COUNT         = 4;

  // Route field codes
  localparam logic [3:0]  ROUTE_NONE         = 4'h0;
  localparam logic [3:0]  ROUTE_SMI          = 4'h2;
  localparam int          LEGACY_IRQ_COUNT   = 16;

  // Battery detect pair patterns, {two, one}
  localparam logic [1:0]  BATTERY_LOW_CODE   = 2'h2;
  localparam logic [1:0]  BATTERY_GOOD_CODE  = 2'h3;

  // Synchronised pin vector layout
  localparam int          PIN_DETECT_A       = 0;
  localparam int          PIN_DETECT_B       = 1;
  localparam int          PIN_READY          = 2;
  localparam int          PIN_BATTERY_ONE    = 3;
  localparam int          PIN_BATTERY_TWO    = 4;
  localparam int          PIN_CARD_IRQ       = 5;
  localparam int          PIN_COUNT          = 6;
  localparam logic [5:0]  PIN_RESET          = 6'h3f;

endpackage

// *** hw/socket_pin_sync.sv ***
// Two-flop synchronisers for the socket input pins, plus one more stage
// holding the previous settled value for edge detection downstream.
// Assumes pins may change at any time relative to i_ref_clk.
`timescale 1ns/1ps
module socket_pin_sync
  import socket_irq_pkg::*;
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset_n,
  input  wire logic [PIN_COUNT-1:0] i_pins,
  output logic      [PIN_COUNT-1:0] o_settled,
  output logic      [PIN_COUNT-1:0] o_previous
);

  logic [PIN_COUNT-1:0] meta_reg;
  logic [PIN_COUNT-1:0] meta_next;
  logic [PIN_COUNT-1:0] settled_reg;
  logic [PIN_COUNT-1:0] settled_next;
  logic [PIN_COUNT-1:0] previous_reg;
  logic [PIN_COUNT-1:0] previous_next;

  // Meta stage feeds only the settled stage, never any logic
  always_comb begin
    meta_next     = i_pins;
    settled_next  = meta_reg;
    previous_next = settled_reg;
  end

  // Reset to idle pin levels so no false edge is seen after reset
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg     <= PIN_RESET;
      settled_reg  <= PIN_RESET;
      previous_reg <= PIN_RESET;
    end else begin
      meta_reg     <= meta_next;
      settled_reg  <= settled_next;
      previous_reg <= previous_next;
    end
  end

  assign o_settled  = settled_reg;
  assign o_previous = previous_reg;

endmodule

// *** hw/card_socket_irq_status_control.sv ***
// Socket interrupt and general control plus card status-change flags.
// Host reaches two 8-bit registers through a simple socket register
// port; reads return data one cycle after the read strobe. Source
// enables, status route field and flag clear mode come from sibling
// registers outside this block as plain inputs.
`timescale 1ns/1ps
module card_socket_irq_status_control
  import socket_irq_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Socket register port
  input  wire logic [11:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // Settings held in neighbouring registers
  input  wire logic        i_detect_event_enable,
  input  wire logic        i_ready_event_enable,
  input  wire logic        i_battery_low_event_enable,
  input  wire logic        i_battery_dead_event_enable,
  input  wire logic [3:0]  i_event_irq_route_field,
  input  wire logic        i_flag_clear_on_write,
  // Card side pins
  input  wire logic        i_card_detect_pin_a_n,
  input  wire logic        i_card_detect_pin_b_n,
  input  wire logic        i_card_ready,
  input  wire logic        i_battery_ring_pin,
  input  wire logic        i_battery_detect_two,
  input  wire logic        i_card_irq_n,
  output logic             o_card_reset,
  output logic             o_card_kind_select,
  output logic             o_ring_indicate_enable,
  // Host interrupt outputs
  output logic             o_pci_int,
  output logic             o_system_mgmt_interrupt,
  output logic      [15:0] o_legacy_irq
);

  logic [PIN_COUNT-1:0]        pin_now;
  logic [PIN_COUNT-1:0]        pin_prev;
  logic [7:0]                  ctrl_reg;
  logic [7:0]                  ctrl_next;
  logic [FLAG_COUNT-1:0]       flags_reg;
  logic [FLAG_COUNT-1:0]       flags_next;
  logic [7:0]                  rdata_reg;
  logic [7:0]                  rdata_next;
  logic                        pci_reg;
  logic                        pci_next;
  logic                        smi_reg;
  logic                        smi_next;
  logic [LEGACY_IRQ_COUNT-1:0] irq_reg;
  logic [LEGACY_IRQ_COUNT-1:0] irq_next;

  logic                        ring_en;
  logic                        io_card;
  logic [3:0]                  card_route;
  logic [FLAG_COUNT-1:0]       src_enable;
  logic [FLAG_COUNT-1:0]       src_event;
  logic [FLAG_COUNT-1:0]       flags_visible;
  logic [FLAG_COUNT-1:0]       flags_clear;
  logic                        ctrl_hit;
  logic                        flags_hit;
  logic [1:0]                  battery_now;
  logic [1:0]                  battery_prev;
  logic                        status_pending;
  logic                        status_to_pci;
  logic                        card_irq_active;

  // Card pins settle through two flops before any edge is looked at
  socket_pin_sync u_pin_sync (
    .i_ref_clk  (i_ref_clk),
    .i_reset_n  (i_reset_n),
    .i_pins     ({i_card_irq_n, i_battery_detect_two, i_battery_ring_pin,
                  i_card_ready, i_card_detect_pin_b_n, i_card_detect_pin_a_n}),
    .o_settled  (pin_now),
    .o_previous (pin_prev)
  );

  // Control fields
  assign ring_en    = ctrl_reg[RING_ENABLE_BIT];
  assign io_card    = ctrl_reg[CARD_KIND_BIT];
  assign card_route = ctrl_reg[ROUTE_FIELD_LSB +: ROUTE_FIELD_WIDTH];
  assign ctrl_hit   = (i_reg_addr == CTRL_OFFSET);
  assign flags_hit  = (i_reg_addr == FLAGS_OFFSET);

  // Battery pair as {two, one}; ring pin doubles as detect one
  assign battery_now  = {pin_now[PIN_BATTERY_TWO], pin_now[PIN_BATTERY_ONE]};
  assign battery_prev = {pin_prev[PIN_BATTERY_TWO], pin_prev[PIN_BATTERY_ONE]};

  // Source enables, with kind gating for the memory-only sources
  always_comb begin
    src_enable                  = '0;
    src_enable[DETECT_FLAG_BIT] = i_detect_event_enable;
    src_enable[READY_FLAG_BIT]  = i_ready_event_enable && !io_card;
    src_enable[LOW_FLAG_BIT]    = i_battery_low_event_enable && !io_card;
    src_enable[DEAD_FLAG_BIT]   = i_battery_dead_event_enable;
  end

  // Raw events from settled pin history
  always_comb begin
    src_event = '0;
    // Either detect pin toggling counts as a change
    src_event[DETECT_FLAG_BIT] = (pin_now[PIN_DETECT_A] ^ pin_prev[PIN_DETECT_A])
                               | (pin_now[PIN_DETECT_B] ^ pin_prev[PIN_DETECT_B]);
    src_event[READY_FLAG_BIT]  = pin_now[PIN_READY] && !pin_prev[PIN_READY];
    // Entering the warning pattern, not staying in it
    // Ring use takes detect one away from battery sensing
    src_event[LOW_FLAG_BIT]    = (battery_now == BATTERY_LOW_CODE)
                               && (battery_prev != BATTERY_LOW_CODE)
                               && !ring_en;
    if (ring_en || io_card) begin
      // Ring and card event share the pin, both active low
      src_event[DEAD_FLAG_BIT] = pin_prev[PIN_BATTERY_ONE]
                               && !pin_now[PIN_BATTERY_ONE];
    end else begin
      // Dead is pattern 00 or 01, i.e. detect two low
      src_event[DEAD_FLAG_BIT] = !battery_now[1] && battery_prev[1];
    end
  end

  // A disabled source never shows a flag
  assign flags_visible = flags_reg & src_enable;

  // Clear by read or by write-one, chosen by the clear mode input
  always_comb begin
    flags_clear = '0;
    if (flags_hit) begin
      if (i_flag_clear_on_write) begin
        if (i_reg_wr) begin
          flags_clear = i_reg_wdata[FLAG_COUNT-1:0];
        end
      end else if (i_reg_rd) begin
        flags_clear = '1;
      end
    end
  end

  // Flag update: set wins over a clear in the same cycle
  always_comb begin
    flags_next = ((flags_reg & ~flags_clear) | (src_event & src_enable))
               & src_enable;
  end

  // Control register, the only writable register here
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_hit && i_reg_wr) begin
      ctrl_next = i_reg_wdata;
    end
  end

  // Read data; status register is read-only, upper bits zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      if (ctrl_hit) begin
        rdata_next = ctrl_reg;
      end else if (flags_hit) begin
        rdata_next = {{(8 - FLAG_COUNT){1'b0}}, flags_visible};
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Interrupt routing; outputs track flags and card request level
  assign status_pending  = |flags_visible;
  assign status_to_pci   = ctrl_reg[PCI_ROUTE_BIT]
                         || (card_route == ROUTE_NONE);
  assign card_irq_active = io_card && !pin_now[PIN_CARD_IRQ];

  always_comb begin
    pci_next = 1'b0;
    smi_next = 1'b0;
    irq_next = '0;
    // Status-change interrupt
    if (status_pending) begin
      if (status_to_pci) begin
        pci_next = 1'b1;
      end else if (i_event_irq_route_field == ROUTE_SMI) begin
        smi_next = 1'b1;
      end else if (i_event_irq_route_field != ROUTE_NONE) begin
        irq_next[i_event_irq_route_field] = 1'b1;
      end
    end
    // Card functional interrupt, only for I/O cards
    if (card_irq_active) begin
      if (card_route == ROUTE_SMI) begin
        smi_next = 1'b1;
      end else if (card_route != ROUTE_NONE) begin
        irq_next[card_route] = 1'b1;
      end
    end
  end

  // All state registers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_reg  <= CTRL_RESET;
      flags_reg <= FLAGS_RESET[FLAG_COUNT-1:0];
      rdata_reg <= 8'h00;
      pci_reg   <= 1'b0;
      smi_reg   <= 1'b0;
      irq_reg   <= '0;
    end else begin
      ctrl_reg  <= ctrl_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
      pci_reg   <= pci_next;
      smi_reg   <= smi_next;
      irq_reg   <= irq_next;
    end
  end

  // Card reset held while the run bit is zero, reset included
  assign o_card_reset            = !ctrl_reg[CARD_RUN_BIT];
  assign o_card_kind_select      = io_card;
  assign o_ring_indicate_enable  = ring_en;
  assign o_reg_rdata             = rdata_reg;
  assign o_pci_int               = pci_reg;
  assign o_system_mgmt_interrupt = smi_reg;
  assign o_legacy_irq            = irq_reg;

endmodule

// *** sim/card_socket_irq_status_control_monitor.sv ***
// Port checker for the socket control and status-change block.
// Assumes it is bound into every instance of that block.
`timescale 1ns/1ps
module card_socket_irq_status_control_monitor
  import socket_irq_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic [11:0] i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_detect_event_enable,
  input wire logic        o_card_reset,
  input wire logic        o_card_kind_select,
  input wire logic        o_ring_indicate_enable,
  input wire logic [15:0] o_legacy_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Host accesses; data lands one cycle after the strobe
  sequence ctrl_wr_s; i_reg_wr && i_reg_addr == CTRL_OFFSET; endsequence
  sequence flag_rd_s; i_reg_rd && i_reg_addr == FLAGS_OFFSET; endsequence
  ring_bit_a: assert property (ctrl_wr_s |=>
    o_ring_indicate_enable == $past(i_reg_wdata[7])) else $error("bad ring enable");
  card_reset_a: assert property (ctrl_wr_s |=>
    o_card_reset == !$past(i_reg_wdata[6])) else $error("bad card reset");
  card_kind_a: assert property (ctrl_wr_s |=>
    o_card_kind_select == $past(i_reg_wdata[5])) else $error("bad card kind");
  upper_zero_a: assert property (flag_rd_s |=> o_reg_rdata[7:4] == 4'h0)
    else $error("flag upper nibble set");
  detect_off_a: assert property (flag_rd_s ##0 !i_detect_event_enable |=>
    !o_reg_rdata[3]) else $error("disabled detect flag set");
  io_zero_a: assert property (flag_rd_s ##0 o_card_kind_select |=>
    o_reg_rdata[2:1] == 2'h0) else $error("memory-only flags on io card");
  unmapped_a: assert property (i_reg_rd && i_reg_addr != CTRL_OFFSET &&
    i_reg_addr != FLAGS_OFFSET |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  no_line_a: assert property (!o_legacy_irq[0] && !o_legacy_irq[2])
    else $error("irq line 0 or 2 driven");
endmodule
bind card_socket_irq_status_control card_socket_irq_status_control_monitor monitor_inst (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_detect_event_enable(i_detect_event_enable), .o_card_reset(o_card_reset),
  .o_card_kind_select(o_card_kind_select), .o_ring_indicate_enable(o_ring_indicate_enable),
  .o_legacy_irq(o_legacy_irq));

// *** sim/pc_card_model.sv ***
// Behavioural 16-bit card sitting in the socket.
// Assumes the bench sets insertion, battery, ring and request levels.
`timescale 1ns/1ps
module pc_card_model #(
  parameter int READY_DELAY = 4
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_card_reset,
  input  wire logic       i_inserted,
  input  wire logic [1:0] i_battery_code,
  input  wire logic       i_ring_n,
  input  wire logic       i_irq_req,
  output logic            o_detect_n,
  output logic            o_ready,
  output logic            o_battery_one,
  output logic            o_battery_two,
  output logic            o_irq_n
);
  int busy = 0;
  // Card stays busy for a while after its reset is removed
  always @(posedge i_ref_clk) begin
    busy <= i_card_reset ? READY_DELAY : (busy > 0 ? busy - 1 : 0);
  end
  assign o_ready = !i_card_reset && busy == 0;
  assign o_detect_n = !i_inserted;
  // Ring shares the battery one line, so either can pull it low
  assign o_battery_one = i_battery_code[0] & i_ring_n;
  assign o_battery_two = i_battery_code[1];
  assign o_irq_n = !i_irq_req;
endmodule

// *** sim/tb.sv ***
// Bench for the socket control and status block with a card model.
// Assumes the package, design, monitor and card model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: %h not %h", $time, a, b); end end
module tb
  import socket_irq_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, clr_wr = 1'b0;
  logic        ins = 1'b0, ring_n = 1'b1, irq = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [3:0]  en = 4'hf, route = 4'h0;
  logic [1:0]  bat = 2'h3;
  logic        det_n, rdy, b1, b2, irq_n, crst, kind, ring, pci, system_mgmt_interrupt;
  logic [15:0] leg;
  logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hb};
  logic [16:0] exp_irq [5] = '{17'h0, 17'h2, 17'h10000, 17'h10, 17'h800};
  int          error_cnt = 0, total_checks = 0, cycles = 0;
  card_socket_irq_status_control card_socket_irq_status_control_inst (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_detect_event_enable(en[3]),
    .i_ready_event_enable(en[2]), .i_battery_low_event_enable(en[1]),
    .i_battery_dead_event_enable(en[0]), .i_event_irq_route_field(route),
    .i_flag_clear_on_write(clr_wr), .i_card_detect_pin_a_n(det_n), .i_card_detect_pin_b_n(det_n),
    .i_card_ready(rdy), .i_battery_ring_pin(b1), .i_battery_detect_two(b2), .i_card_irq_n(irq_n),
    .o_card_reset(crst), .o_card_kind_select(kind), .o_ring_indicate_enable(ring),
    .o_pci_int(pci), .o_system_mgmt_interrupt(system_mgmt_interrupt), .o_legacy_irq(leg));
  pc_card_model pc_card_model_inst (.i_ref_clk(clk), .i_card_reset(crst), .i_inserted(ins),
    .i_battery_code(bat), .i_ring_n(ring_n), .i_irq_req(irq), .o_detect_n(det_n),
    .o_ready(rdy), .o_battery_one(b1), .o_battery_two(b2), .o_irq_n(irq_n));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One idle cycle after each strobe so two strobes never merge
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    w(1);
    wr = 1'b0;
    w(1);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    w(1);
    rd = 1'b0;
    `CHK(rdata, e)
    w(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  // Whole run needs under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    w(8);
    rst_n = 1'b1;
    w(1);
    `CHK(crst, 1'b1)
    chk_rd(CTRL_OFFSET, 8'h00);
    chk_rd(FLAGS_OFFSET, 8'h00);
    chk_rd(12'h805, 8'h00);
    // Card leaves reset and its ready line rises
    reg_wr(CTRL_OFFSET, 8'h40);
    `CHK(crst, 1'b0)
    w(10);
    `CHK(pci, 1'b1)
    chk_rd(FLAGS_OFFSET, 8'h04);
    `CHK(pci, 1'b0)
    chk_rd(FLAGS_OFFSET, 8'h00);
    // Write-one mode: reads leave flags alone
    clr_wr = 1'b1;
    ins = 1'b1;
    w(6);
    chk_rd(FLAGS_OFFSET, 8'h08);
    reg_wr(FLAGS_OFFSET, 8'hf7);
    chk_rd(FLAGS_OFFSET, 8'h08);
    reg_wr(FLAGS_OFFSET, 8'h08);
    chk_rd(FLAGS_OFFSET, 8'h00);
    bat = 2'h2;
    w(6);
    chk_rd(FLAGS_OFFSET, 8'h02);
    bat = 2'h0;
    w(6);
    chk_rd(FLAGS_OFFSET, 8'h03);
    reg_wr(FLAGS_OFFSET, 8'h03);
    bat = 2'h3;
    en = 4'h0;
    ins = 1'b0;
    w(6);
    chk_rd(FLAGS_OFFSET, 8'h00);
    en = 4'hf;
    ins = 1'b1;
    w(6);
    reg_wr(CTRL_OFFSET, 8'h4b);
    for (int i = 0; i < 5; i++) begin
      route = codes[i];
      w(2);
      `CHK({system_mgmt_interrupt, leg}, exp_irq[i])
    end
    reg_wr(CTRL_OFFSET, 8'h5b);
    `CHK({pci, system_mgmt_interrupt, leg}, 18'h20000)
    reg_wr(FLAGS_OFFSET, 8'h08);
    `CHK(pci, 1'b0)
    // I/O card: ready rise is hidden, card request follows the field
    reg_wr(CTRL_OFFSET, 8'h20);
    `CHK(crst, 1'b1)
    w(10);
    reg_wr(CTRL_OFFSET, 8'h60);
    `CHK(kind, 1'b1)
    w(10);
    chk_rd(FLAGS_OFFSET, 8'h00);
    irq = 1'b1;
    w(6);
    for (int i = 0; i < 5; i++) begin
      reg_wr(CTRL_OFFSET, {4'h6, codes[i]});
      `CHK({system_mgmt_interrupt, leg}, exp_irq[i])
    end
    irq = 1'b0;
    reg_wr(CTRL_OFFSET, 8'hc0);
    `CHK(ring, 1'b1)
    `CHK(kind, 1'b0)
    ring_n = 1'b0;
    w(6);
    chk_rd(FLAGS_OFFSET, 8'h01);
    chk_rd(CTRL_OFFSET, 8'hc0);
    wrap_up();
  end
endmodule
